// ==== rtl/esm_top.sv ====
// Our own choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module esm_top
  import esm_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic fe_clk,
  input wire logic fe_data,
  output logic fe_conv,
  output logic fe_chan,
  output logic heater_on,
  output logic alert_output_pin,
  output logic alert_output_pin_oe_n
);

  esm_core_t s;
  esm_core_t n;

  logic rx_done;
  logic [15:0] rx_result;
  logic [3:0] rx_nbits;
  logic req;
  logic first;
  logic take;
  logic [3:0] idx;
  logic ms_tick;
  logic auto_go;
  logic [2:0] rate;
  logic latch;
  logic act;
  logic src_ok;

  // byte lanes 0 and 1 carry the 16-bit registers
  function automatic logic [15:0] merge16(
    input logic [15:0] old,
    input logic [31:0] wd,
    input logic [3:0] be
  );
    merge16 = old;
    if (be[0]) begin
      merge16[7:0] = wd[7:0];
    end
    if (be[1]) begin
      merge16[15:8] = wd[15:8];
    end
  endfunction : merge16

  // comparator mode follows the result, latched mode only accumulates
  function automatic logic upd_flag(
    input logic flag,
    input logic en,
    input logic viol,
    input logic comp
  );
    if (comp) begin
      upd_flag = en & viol;
    end else begin
      upd_flag = flag | (en & viol);
    end
  endfunction : upd_flag

  assign rx_nbits = s.fe.chan ? res_bits(s.meas[M_HRES +: 2])
                              : res_bits(s.meas[M_TRES +: 2]);

  esm_fe_rx u_rx (
    .clock(clock),
    .rst_n(rst_n),
    .fe_clk(fe_clk),
    .fe_data(fe_data),
    .start(s.conv_start),
    .nbits(rx_nbits),
    .done(rx_done),
    .result(rx_result)
  );

  always_comb begin
    n = s;
    n.conv_start = 1'b0;
    auto_go = 1'b0;
    act = 1'b0;
    src_ok = 1'b1;
    rate = s.cfg[B_RATE +: 3];
    latch = s.cfg[B_LATCH];
    idx = avs_address[5:2];
    req = avs_read | avs_write;
    // one wait cycle: sample on the first edge, release on the second
    first = req & s.wreq;
    take = req & ~s.wreq;
    n.wreq = ~first;

    if (first && avs_read) begin
      case (idx)
        IX_TEMP: n.rdata = {16'h0000, s.temp};
        IX_HUM: n.rdata = {16'h0000, s.hum};
        IX_STATUS: n.rdata = {24'h000000, s.flags, 3'h0};
        IX_ALERT_EN: n.rdata = {24'h000000, s.alert_en, 3'h0};
        IX_TEMP_LO: n.rdata = {16'h0000, s.t_lo};
        IX_TEMP_HI: n.rdata = {16'h0000, s.t_hi};
        IX_HUM_LO: n.rdata = {16'h0000, s.h_lo};
        IX_HUM_HI: n.rdata = {16'h0000, s.h_hi};
        IX_CFG: n.rdata = {24'h000000, s.cfg};
        IX_MEAS: n.rdata = {27'h0000000, s.meas};
        default: n.rdata = 32'h00000000;
      endcase
      // clear on the same edge the value is captured, so nothing slips between
      if (idx == IX_STATUS) begin
        n.flags[F_DONE] = 1'b0;
        if (!latch) begin
          n.flags[F_TH] = 1'b0;
          n.flags[F_TL] = 1'b0;
          n.flags[F_HH] = 1'b0;
          n.flags[F_HL] = 1'b0;
        end
      end
    end

    ms_tick = (s.ms_cnt == 16'(MS_CYC - 1));
    if (ms_tick) begin
      n.ms_cnt = 16'h0000;
    end else begin
      n.ms_cnt = s.ms_cnt + 16'h0001;
    end

    if (rate == 3'h0) begin
      n.per_cnt = 17'h00000;
    end else if (ms_tick) begin
      // a rate change takes effect at the next compare, no restart
      if (s.per_cnt >= interval_ms(rate) - 17'h00001) begin
        n.per_cnt = 17'h00000;
        auto_go = 1'b1;
      end else begin
        n.per_cnt = s.per_cnt + 17'h00001;
      end
    end

    // flag sets below come after the read clear, so a set wins
    case (s.st)
      ST_SLEEP: begin
        if (s.meas[M_START] || auto_go) begin
          n.meas[M_START] = 1'b0;
          n.st = ST_TEMP;
          n.conv_start = 1'b1;
          n.fe.conv = 1'b1;
          n.fe.chan = 1'b0;
        end
      end
      ST_TEMP: begin
        if (rx_done) begin
          n.temp = rx_result;
          n.flags[F_TH] = upd_flag(s.flags[F_TH], s.alert_en[F_TH],
                                   rx_result > s.t_hi, latch);
          n.flags[F_TL] = upd_flag(s.flags[F_TL], s.alert_en[F_TL],
                                   rx_result < s.t_lo, latch);
          if (s.alert_en[F_DONE]) begin
            n.flags[F_DONE] = 1'b1;
          end
          n.st = ST_HUM;
          n.conv_start = 1'b1;
          n.fe.chan = 1'b1;
        end
      end
      ST_HUM: begin
        if (rx_done) begin
          n.hum = rx_result;
          n.flags[F_HH] = upd_flag(s.flags[F_HH], s.alert_en[F_HH],
                                   rx_result > s.h_hi, latch);
          n.flags[F_HL] = upd_flag(s.flags[F_HL], s.alert_en[F_HL],
                                   rx_result < s.h_lo, latch);
          if (s.alert_en[F_DONE]) begin
            n.flags[F_DONE] = 1'b1;
          end
          n.st = ST_SLEEP;
          n.fe.conv = 1'b0;
          n.fe.chan = 1'b0;
        end
      end
      default: begin
        n.st = ST_SLEEP;
        n.fe.conv = 1'b0;
        n.fe.chan = 1'b0;
      end
    endcase

    if (take && avs_write) begin
      case (idx)
        IX_ALERT_EN: begin
          if (avs_byteenable[0]) begin
            n.alert_en = avs_writedata[FLAG_LSB +: 5];
          end
        end
        IX_TEMP_LO: n.t_lo = merge16(s.t_lo, avs_writedata, avs_byteenable);
        IX_TEMP_HI: n.t_hi = merge16(s.t_hi, avs_writedata, avs_byteenable);
        IX_HUM_LO: n.h_lo = merge16(s.h_lo, avs_writedata, avs_byteenable);
        IX_HUM_HI: n.h_hi = merge16(s.h_hi, avs_writedata, avs_byteenable);
        IX_CFG: begin
          if (avs_byteenable[0]) begin
            n.cfg = avs_writedata[7:0];
          end
        end
        IX_MEAS: begin
          if (avs_byteenable[0]) begin
            n.meas = avs_writedata[4:0];
          end
        end
        default: begin
        end
      endcase
    end

    // alert source by fixed priority, one at a time
    if (n.alert_en[F_TH]) begin
      act = n.flags[F_TH];
    end else if (n.alert_en[F_TL]) begin
      act = n.flags[F_TL];
    end else if (n.alert_en[F_HH]) begin
      act = n.flags[F_HH];
    end else if (n.alert_en[F_HL]) begin
      act = n.flags[F_HL];
    end else if (n.alert_en[F_DONE]) begin
      act = n.flags[F_DONE];
      src_ok = ~n.cfg[B_LATCH];
    end

    n.alert_oe_n = ~(n.cfg[B_DRV_EN] & src_ok);
    n.alert_pin = n.cfg[B_POL] ? act : ~act;
    n.heater = n.cfg[B_HEAT];
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{st: ST_SLEEP,
             wreq: 1'b1,
             cfg: CFG_RST,
             meas: MEAS_RST,
             alert_en: EN_RST,
             t_hi: THR_HI_RST,
             t_lo: THR_LO_RST,
             h_hi: THR_HI_RST,
             h_lo: THR_LO_RST,
             alert_pin: 1'b1,
             alert_oe_n: 1'b1,
             default: '0};
    end else begin
      s <= n;
    end
  end

  assign avs_readdata = s.rdata;
  assign avs_waitrequest = s.wreq;
  assign fe_conv = s.fe.conv;
  assign fe_chan = s.fe.chan;
  assign heater_on = s.heater;
  assign alert_output_pin = s.alert_pin;
  assign alert_output_pin_oe_n = s.alert_oe_n;

endmodule : esm_top
`default_nettype wire

// ==== include/esm_pkg.sv ====
package esm_pkg;

  localparam int CLK_PERIOD_NS = 25;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // register indices; byte address is four times the index
  localparam logic [3:0] IX_TEMP = 4'h0;
  localparam logic [3:0] IX_HUM = 4'h2;
  localparam logic [3:0] IX_STATUS = 4'h4;
  localparam logic [3:0] IX_ALERT_EN = 4'h7;
  localparam logic [3:0] IX_TEMP_LO = 4'hA;
  localparam logic [3:0] IX_TEMP_HI = 4'hB;
  localparam logic [3:0] IX_HUM_LO = 4'hC;
  localparam logic [3:0] IX_HUM_HI = 4'hD;
  localparam logic [3:0] IX_CFG = 4'hE;
  localparam logic [3:0] IX_MEAS = 4'hF;

  // configuration register fields
  localparam int B_LATCH = 0;
  localparam int B_POL = 1;
  localparam int B_DRV_EN = 2;
  localparam int B_HEAT = 3;
  localparam int B_RATE = 4;

  // measurement register fields
  localparam int M_START = 0;
  localparam int M_TRES = 1;
  localparam int M_HRES = 3;

  // flag and enable positions, status byte holds them at bits [7:3]
  localparam int F_HL = 0;
  localparam int F_HH = 1;
  localparam int F_TL = 2;
  localparam int F_TH = 3;
  localparam int F_DONE = 4;
  localparam int FLAG_LSB = 3;

  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [4:0] MEAS_RST = 5'h00;
  localparam logic [4:0] EN_RST = 5'h00;
  localparam logic [15:0] THR_HI_RST = 16'hFFFF;
  localparam logic [15:0] THR_LO_RST = 16'h0000;

  typedef enum logic [1:0] {
    ST_SLEEP = 2'h0,
    ST_TEMP = 2'h1,
    ST_HUM = 2'h3
  } esm_state_t;

  typedef struct packed {
    logic conv;
    logic chan;
  } esm_fe_t;

  typedef struct packed {
    logic [1:0] clk_sync;
    logic [1:0] dat_sync;
    logic clk_prev;
    logic active;
    logic [3:0] pos;
    logic [15:0] shreg;
    logic done;
  } esm_rx_t;

  typedef struct packed {
    esm_state_t st;
    logic wreq;
    logic [31:0] rdata;
    logic [15:0] temp;
    logic [15:0] hum;
    logic [4:0] flags;
    logic [4:0] alert_en;
    logic [15:0] t_lo;
    logic [15:0] t_hi;
    logic [15:0] h_lo;
    logic [15:0] h_hi;
    logic [7:0] cfg;
    logic [4:0] meas;
    logic [15:0] ms_cnt;
    logic [16:0] per_cnt;
    logic conv_start;
    esm_fe_t fe;
    logic alert_pin;
    logic alert_oe_n;
    logic heater;
  } esm_core_t;

  // 2'b00 14 bit, 2'b01 11 bit, 2'b10 9 bit, 2'b11 14 bit
  function automatic logic [3:0] res_bits(input logic [1:0] code);
    case (code)
      2'h1: res_bits = 4'hB;
      2'h2: res_bits = 4'h9;
      default: res_bits = 4'hE;
    endcase
  endfunction : res_bits

  // sampling interval in ms; rate 0 means on demand
  function automatic logic [16:0] interval_ms(input logic [2:0] rate);
    case (rate)
      3'h1: interval_ms = 17'h1D4C0;
      3'h2: interval_ms = 17'h0EA60;
      3'h3: interval_ms = 17'h02710;
      3'h4: interval_ms = 17'h01388;
      3'h5: interval_ms = 17'h003E8;
      3'h6: interval_ms = 17'h001F4;
      3'h7: interval_ms = 17'h000C8;
      default: interval_ms = 17'h00000;
    endcase
  endfunction : interval_ms

endpackage : esm_pkg

// ==== rtl/esm_fe_rx.sv ====
`timescale 1ns/1ps
`default_nettype none
module esm_fe_rx
  import esm_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic fe_clk,
  input wire logic fe_data,
  input wire logic start,
  input wire logic [3:0] nbits,
  output logic done,
  output logic [15:0] result
);

  esm_rx_t s;
  esm_rx_t n;
  logic rise;

  always_comb begin
    n = s;
    n.done = 1'b0;
    n.clk_sync = {s.clk_sync[0], fe_clk};
    n.dat_sync = {s.dat_sync[0], fe_data};
    n.clk_prev = s.clk_sync[1];
    rise = s.clk_sync[1] & ~s.clk_prev;
    if (start) begin
      n.active = 1'b1;
      n.pos = 4'h0;
      n.shreg = 16'h0000;
    end else if (s.active && rise) begin
      // msb first, left aligned so every resolution compares alike
      n.shreg[4'hF - s.pos] = s.dat_sync[1];
      n.pos = s.pos + 4'h1;
      if (s.pos == nbits - 4'h1) begin
        n.active = 1'b0;
        n.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{default: '0};
    end else begin
      s <= n;
    end
  end

  assign done = s.done;
  assign result = s.shreg;

endmodule : esm_fe_rx
`default_nettype wire

// ==== testbench/esm_fe_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module esm_fe_model (
  input wire logic fe_conv,
  input wire logic fe_chan,
  input wire logic [15:0] t_val,
  input wire logic [15:0] h_val,
  input wire logic [3:0] nb,
  output logic fe_clk,
  output logic fe_data
);
  logic [15:0] v;
  initial begin
    fe_clk = 1'b0;
    fe_data = 1'b0;
  end
  // clock stands still between frames; a released data line shows the inverse
  always begin
    wait (fe_conv === 1'b1);
    for (int c = 0; c < 2; c++) begin
      wait (fe_chan === c[0]);
      // settle gap, the block may miss an edge right after a channel switch
      #150;
      v = c[0] ? h_val : t_val;
      for (int i = 0; i < nb; i++) begin
        fe_data = v[15 - i];
        #100 fe_clk = 1'b1;
        #100 fe_clk = 1'b0;
      end
      fe_data = ~fe_data;
    end
    wait (fe_conv === 1'b0);
  end
endmodule : esm_fe_model
`default_nettype wire

// ==== testbench/esm_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module esm_chk
  import esm_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic fe_clk,
  input wire logic fe_data,
  input wire logic fe_conv,
  input wire logic fe_chan,
  input wire logic heater_on,
  input wire logic alert_output_pin,
  input wire logic alert_output_pin_oe_n
);
  logic [1:0] fs;
  logic fq, ch_q, cv_q, chg;
  logic [4:0] ecnt;
  logic [3:0] ev;
  assign chg = (fe_chan ^ ch_q) | (fe_conv ^ cv_q);
  // same two-stage sampling as the block, so edge counts line up
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fs <= 2'h0;
      fq <= 1'b0;
      ch_q <= 1'b0;
      cv_q <= 1'b0;
      ecnt <= 5'h00;
      ev <= 4'h0;
    end else begin
      fs <= {fs[0], fe_clk};
      fq <= fs[1];
      ch_q <= fe_chan;
      cv_q <= fe_conv;
      ecnt <= chg ? 5'h00 : ecnt + 5'(fs[1] & ~fq);
      // a status read clears flags at its capture edge, a write lands one edge later
      ev <= {ev[2:0], chg | avs_read | avs_write};
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=>
    !avs_waitrequest ##1 avs_waitrequest) else $error("wait not one cycle");
  temp_first_a: assert property ($rose(fe_conv) |-> !fe_chan)
    else $error("conversion not begun with temperature");
  chan_in_conv_a: assert property (fe_chan |-> fe_conv) else $error("channel outside run");
  hum_last_a: assert property ($fell(fe_conv) |-> $past(fe_chan))
    else $error("run ended before humidity");
  temp_bits_a: assert property ($rose(fe_chan) |-> ecnt inside {9, 11, 14})
    else $error("temperature bit count wrong");
  hum_bits_a: assert property ($fell(fe_conv) |-> ecnt inside {9, 11, 14})
    else $error("humidity bit count wrong");
  heat_write_a: assert property ($changed(heater_on) |->
    $past(avs_write && !avs_waitrequest) || $past(avs_write && !avs_waitrequest, 2))
    else $error("heater moved without a write");
  pin_cause_a: assert property ($changed(alert_output_pin) |-> (|ev) || chg)
    else $error("alert moved without cause");
  cover property ($rose(fe_conv));
  cover property ($fell(alert_output_pin_oe_n));
  cover property ($rose(heater_on));
endmodule : esm_chk
bind esm_top esm_chk esm_chk_inst (.clock(clock), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .fe_clk(fe_clk), .fe_data(fe_data), .fe_conv(fe_conv),
  .fe_chan(fe_chan), .heater_on(heater_on), .alert_output_pin(alert_output_pin),
  .alert_output_pin_oe_n(alert_output_pin_oe_n));
`default_nettype wire

// ==== testbench/esm_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH %s exp %h seen %h", nm, e, g); end end
module esm_top_tb
  import esm_pkg::*;
;
  localparam int MSC = 4;
  logic clock, rst_n, avs_read, avs_write, avs_waitrequest, fe_clk, fe_data, fe_conv, fe_chan;
  logic heater_on, alert_output_pin, alert_output_pin_oe_n;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rdv;
  logic [3:0] avs_byteenable, nb;
  logic [15:0] tval, hval;
  logic [1:0] res;
  int mismatches, n_checks, cyc, dur;
  esm_top #(.MS_CYC(MSC)) esm_top_inst (.clock(clock), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .fe_clk(fe_clk),
    .fe_data(fe_data), .fe_conv(fe_conv), .fe_chan(fe_chan), .heater_on(heater_on),
    .alert_output_pin(alert_output_pin), .alert_output_pin_oe_n(alert_output_pin_oe_n));
  esm_fe_model esm_fe_model_inst (.fe_conv(fe_conv), .fe_chan(fe_chan), .t_val(tval),
    .h_val(hval), .nb(nb), .fe_clk(fe_clk), .fe_data(fe_data));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      mismatches++;
      summarize();
    end
  end
  // request held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [3:0] ix, input logic [31:0] wd);
    avs_address <= {ix, 2'h0};
    avs_writedata <= wd;
    avs_write <= w;
    avs_read <= ~w;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    rdv = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clock);
  endtask : bus
  task automatic wr(input logic [3:0] ix, input logic [31:0] d);
    bus(1'b1, ix, d);
  endtask : wr
  task automatic rd(input logic [3:0] ix);
    bus(1'b0, ix, 32'h0);
  endtask : rd
  task automatic meas(input logic [15:0] tv, input logic [15:0] hv);
    int t0;
    t0 = cyc;
    tval <= tv;
    hval <= hv;
    wr(IX_MEAS, {27'h0, res, res, 1'b1});
    while (fe_conv !== 1'b1) @(posedge clock);
    while (fe_conv !== 1'b0) @(posedge clock);
    dur = cyc - t0;
    repeat (4) @(posedge clock);
  endtask : meas
  task automatic rise();
    while (fe_conv !== 1'b0) @(posedge clock);
    while (fe_conv !== 1'b1) @(posedge clock);
  endtask : rise
  task automatic t_reset();
    `CHK("pin", 1'b1, alert_output_pin)
    `CHK("oe_n", 1'b1, alert_output_pin_oe_n)
    rd(IX_TEMP_HI);
    `CHK("thr_hi", 32'h0000FFFF, rdv)
    rd(4'h1);
    `CHK("unmapped", 32'h0, rdv)
    repeat (100) @(posedge clock);
    `CHK("asleep", 1'b0, fe_conv)
    $display("done reset");
  endtask : t_reset
  task automatic t_demand();
    int prev;
    int nbt[3];
    logic [15:0] m;
    prev = 0;
    nbt = '{14, 11, 9};
    for (int k = 2; k >= 0; k--) begin
      res = 2'(k);
      nb = 4'(nbt[k]);
      m = 16'hFFFF << (16 - nb);
      meas(16'hA5C3, 16'h3C5A);
      rd(IX_TEMP);
      `CHK("temp", {16'h0, 16'hA5C3 & m}, rdv)
      rd(IX_HUM);
      `CHK("hum", {16'h0, 16'h3C5A & m}, rdv)
      `CHK("longer", 1'b1, dur > prev)
      prev = dur;
    end
    repeat (300) @(posedge clock);
    `CHK("stays asleep", 1'b0, fe_conv)
    $display("done demand");
  endtask : t_demand
  task automatic t_done();
    wr(IX_ALERT_EN, 32'h80);
    wr(IX_CFG, 32'h06);
    meas(16'h1000, 16'h1000);
    `CHK("done pin", 1'b1, alert_output_pin)
    `CHK("done oe_n", 1'b0, alert_output_pin_oe_n)
    rd(IX_STATUS);
    `CHK("done flag", 1'b1, rdv[7])
    repeat (2) @(posedge clock);
    `CHK("done cleared", 1'b0, alert_output_pin)
    wr(IX_CFG, 32'h04);
    repeat (2) @(posedge clock);
    `CHK("active low", 1'b1, alert_output_pin)
    wr(IX_CFG, 32'h05);
    repeat (2) @(posedge clock);
    `CHK("latch hi z", 1'b1, alert_output_pin_oe_n)
    wr(IX_CFG, 32'h00);
    repeat (2) @(posedge clock);
    `CHK("hi z", 1'b1, alert_output_pin_oe_n)
    $display("done ready");
  endtask : t_done
  task automatic t_thresh();
    wr(IX_CFG, 32'h07);
    wr(IX_TEMP_HI, 32'h8000);
    wr(IX_HUM_HI, 32'h4000);
    wr(IX_TEMP_LO, 32'h2000);
    wr(IX_HUM_LO, 32'h2000);
    wr(IX_ALERT_EN, 32'h50);
    meas(16'h3000, 16'h8000);
    `CHK("no or", 1'b0, alert_output_pin)
    rd(IX_STATUS);
    `CHK("hum high", 8'h10, rdv[7:0] & 8'h78)
    meas(16'h9000, 16'h8000);
    `CHK("temp high", 1'b1, alert_output_pin)
    wr(IX_ALERT_EN, 32'h30);
    meas(16'h1000, 16'h1000);
    `CHK("temp low", 1'b1, alert_output_pin)
    meas(16'h3000, 16'h8000);
    `CHK("low over hum", 1'b0, alert_output_pin)
    wr(IX_CFG, 32'h06);
    wr(IX_ALERT_EN, 32'h48);
    rd(IX_STATUS);
    meas(16'h9000, 16'h1000);
    meas(16'h3000, 16'h3000);
    `CHK("held pin", 1'b1, alert_output_pin)
    rd(IX_STATUS);
    `CHK("held flags", 8'h48, rdv[7:0] & 8'h78)
    rd(IX_STATUS);
    `CHK("read clears", 8'h00, rdv[7:0] & 8'h78)
    wr(IX_ALERT_EN, 32'h0);
    $display("done thresholds");
  endtask : t_thresh
  task automatic t_periodic();
    int t0;
    int gap[2];
    gap = '{200, 500};
    for (int k = 0; k < 2; k++) begin
      wr(IX_CFG, {25'h0, 3'(7 - k), 4'h0});
      // first wake after a rate change is not aligned, so time the next pair
      rise();
      rise();
      t0 = cyc;
      rise();
      `CHK("interval", gap[k] * MSC, cyc - t0)
    end
    wr(IX_CFG, 32'h0);
    while (fe_conv !== 1'b0) @(posedge clock);
    $display("done periodic");
  endtask : t_periodic
  task automatic t_heater();
    wr(IX_CFG, 32'h08);
    repeat (2) @(posedge clock);
    `CHK("heat on", 1'b1, heater_on)
    meas(16'h5000, 16'h0000);
    rd(IX_HUM);
    `CHK("dry", 32'h0, rdv)
    wr(IX_CFG, 32'h00);
    repeat (2) @(posedge clock);
    `CHK("heat off", 1'b0, heater_on)
    $display("done heater");
  endtask : t_heater
  initial begin
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 6'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h3;
    tval = 16'h0;
    hval = 16'h0;
    nb = 4'hE;
    res = 2'h0;
    mismatches = 0;
    n_checks = 0;
    cyc = 0;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    t_reset();
    t_demand();
    t_done();
    t_thresh();
    t_periodic();
    t_heater();
    summarize();
  end
endmodule : esm_top_tb
`default_nettype wire
